// ---- rtl/pm_pkg.sv ----
// constants and types shared by the reset and power-mode controller
package pm_pkg;
   // digital register offsets
   localparam logic [7:0] ADDR_GRP0 = 8'h60;
   localparam logic [7:0] ADDR_GRP1 = 8'h61;
   localparam logic [7:0] ADDR_GRP2 = 8'h62;
   localparam logic [7:0] ADDR_PWDN = 8'h6f;
   // analog register offsets
   localparam logic [7:0] ADDR_APD = 8'h05;
   localparam logic [7:0] ADDR_MODE = 8'h1f;
   localparam logic [7:0] ADDR_DLY = 8'h20;
   localparam logic [7:0] ADDR_RET_LO = 8'h34;
   localparam logic [7:0] ADDR_RET_HI = 8'h3a;
   localparam logic [7:0] ADDR_RET_END = 8'h3e;
   localparam int RET_N = 11;
   localparam int RET_LO_N = 6;
   // values after reset
   localparam logic [7:0] DLY_RST = 8'hb0;
   localparam logic [7:0] GRP0_RST = 8'h00;
   localparam logic [7:0] GRP1_RST = 8'hdf;
   localparam logic [7:0] GRP2_RST = 8'h00;
   localparam logic [7:0] APD_RST = 8'he0;
   localparam logic [7:0] GRP0_MASK = 8'hf7;
   // field positions
   localparam int PWDN_SUSP = 0;
   localparam int PWDN_CHIP = 5;
   localparam int PWDN_STALL = 7;
   localparam int DLY_OLD = 7;
   localparam int GRP2_MEM = 4;
   localparam int GRP2_MEM_EN = 5;
   // synchronised input lanes
   localparam int IN_LOCK = 0;
   localparam int IN_PIN = 1;
   localparam int IN_XTAL = 2;
   localparam int IN_WPIN = 3;
   localparam int IN_WTMR = 4;
   localparam int IN_SLOW = 5;
   localparam int N_IN = 6;
   // timing
   localparam int CLK_NS = 100;
   localparam int SUSP_WAKE_NS = 400_000;
   localparam int SUSP_WAKE_CYC = (SUSP_WAKE_NS + CLK_NS - 1) / CLK_NS;
   // reported working mode
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_IDLE = 2'h1;
   localparam logic [1:0] MODE_SUSPEND = 2'h2;
   localparam logic [1:0] MODE_DEEP = 2'h3;
   typedef enum logic [3:0] {
      st_lockout, st_xtal, st_delay, st_active, st_idle,
      st_suspend, st_susp_wake, st_deep
   } pm_state_t;
endpackage

// ---- rtl/sync_if.sv ----
// bundle of raw pin levels and their filtered copies
`timescale 1ns/1ps
interface sync_if #(parameter int W = 1);
   logic [W-1:0] raw;
   logic [W-1:0] clean;
   modport src (output raw, input clean);
   modport snk (input raw, output clean);
endinterface

// ---- rtl/pin_sync.sv ----
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // pins in, filtered levels out
   sync_if.snk s
);
   typedef struct packed {
      logic [W-1:0] f1;
      logic [W-1:0] f2;
      logic [W-1:0] f3;
      logic [W-1:0] clean;
   } sync_state_t;

   sync_state_t q, d;

   always_comb begin
      d = q;
      d.f1 = s.raw;
      d.f2 = q.f1;
      d.f3 = q.f2;
      // a change counts only once stages two and three agree
      for (int i = 0; i < W; i++) begin
         if (q.f2[i] == q.f3[i]) begin
            d.clean[i] = q.f3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign s.clean = q.clean;
endmodule

// ---- rtl/pm_ctrl.sv ----
// reset and power-mode controller: working modes, resets, release delay
`timescale 1ns/1ps
//
// Functional notes
// - four working modes active, idle, suspend, deep sleep under software control.
// - idle stalls the processor only; radio untouched; return to active at once.
// - suspend powers radio down, stops processor clock; wake takes 400us.
// - deep sleep switches core regulator off; suspend keeps it on.
// - deep sleep wakeup runs the power-up release path, about 1ms.
// - upper retention bytes 0x3a-0x3e survive deep sleep, watchdog, chip reset.
// - lower retention bytes 0x34-0x39 survive deep sleep, cleared by chip resets.
// - power-on reset returns every register, retention included, to default.
// - writing bit 5 of power-down control resets chip like the watchdog.
// - a module reset bit holds its module in reset while one.
// - group 0 bit map, bit 3 reserved.
// - group 2 bit 5 enables software reset of the memory controller.
// - stall trigger enters suspend if bit 0 set (deep sleep if mode register bit 0 set), else stalls processor.
// - release waits for supply lockout and external reset pin, then delay.
// - delay bit 7 zero waits crystal ready first; one uses counter only.
// - delay field counts slow ticks, bits 0 and 6 swapped; 7'h7e gives 32.
// - release delay defaults 0xb0, restored only by power, watchdog, chip reset.
// - slow RC keeps running in power saving; pin or wake timer wakes.
// - analog power-down bits 0-3 switch off the four oscillators, default 0.
module pm_ctrl
   import pm_pkg::*;
(
   // clock and power-on reset
   input wire logic clk,
   input wire logic nrst,
   // asynchronous pins and analog status
   input wire logic supply_lockout_released,
   input wire logic external_reset_pin_n,
   input wire logic xtal_ready,
   input wire logic wake_pin,
   input wire logic low_freq_wake_timer,
   input wire logic slow_clk,
   // same-clock events
   input wire logic cpu_irq,
   input wire logic wdt_reset,
   // register port
   input wire logic reg_ana,
   input wire logic [7:0] reg_addr,
   input wire logic reg_wr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // mode and power controls
   output logic [1:0] mode,
   output logic system_released,
   output logic cpu_stall,
   output logic cpu_clk_stop,
   output logic radio_power_down,
   output logic core_ldo_off,
   // module resets
   output logic [23:0] module_reset,
   output logic mem_ctrl_reset,
   // analog power-down lines
   output logic slow_rc_power_down,
   output logic slow_crystal_power_down,
   output logic fast_rc_power_down,
   output logic crystal_regulator_power_down,
   output logic [3:0] analog_power_down_other
);
   typedef struct packed {
      pm_state_t st;
      logic [7:0] dly;
      logic [7:0] grp0;
      logic [7:0] grp1;
      logic [7:0] grp2;
      logic [7:0] apd;
      logic deep_sel;
      logic [RET_N-1:0][7:0] ret;
      logic [11:0] cnt;
      logic [6:0] ticks;
      logic slow_prev;
      logic [7:0] rdata;
   } pm_ctrl_state_t;

   localparam pm_ctrl_state_t POR_S = '{
      st: st_lockout, dly: DLY_RST, grp0: GRP0_RST, grp1: GRP1_RST,
      grp2: GRP2_RST, apd: APD_RST, deep_sel: 1'b0, ret: '0, cnt: '0,
      ticks: '0, slow_prev: 1'b0, rdata: '0};
   localparam logic [11:0] SUSP_LAST = 12'(SUSP_WAKE_CYC - 1);

   pm_ctrl_state_t q, d;
   sync_if #(.W(N_IN)) pins ();

   logic power_ok, released, dig_wr, ana_wr, chip_rst, slow_rise, wake;
   logic pwdn_wr, in_ret;
   logic [3:0] ret_idx;
   logic [6:0] target;
   logic [7:0] rd_val;

   assign pins.raw = {slow_clk, low_freq_wake_timer, wake_pin, xtal_ready,
                      external_reset_pin_n, supply_lockout_released};

   pin_sync #(.W(N_IN)) u_sync (
      .clk(clk),
      .nrst(nrst),
      .s(pins.snk)
   );

   // unswap bits 0 and 6, halve, then add one: 7'h7e gives 32 slow ticks
   function automatic logic [6:0] delay_ticks(input logic [6:0] f);
      logic [6:0] u;
      u = {f[0], f[5:1], f[6]};
      return {1'b0, u[6:1]} + 7'd1;
   endfunction

   always_comb begin
      power_ok = pins.clean[IN_LOCK] & pins.clean[IN_PIN];
      released = (q.st == st_active) || (q.st == st_idle);
      dig_wr = reg_wr & ~reg_ana & released;
      ana_wr = reg_wr & reg_ana & released;
      pwdn_wr = dig_wr && (reg_addr == ADDR_PWDN);
      chip_rst = wdt_reset | (pwdn_wr & reg_wdata[PWDN_CHIP]);
      slow_rise = pins.clean[IN_SLOW] & ~q.slow_prev;
      wake = pins.clean[IN_WPIN] | pins.clean[IN_WTMR];
      in_ret = (reg_addr >= ADDR_RET_LO) && (reg_addr <= ADDR_RET_END);
      ret_idx = 4'(reg_addr - ADDR_RET_LO);
      target = delay_ticks(q.dly[6:0]);
   end

   // read data source
   always_comb begin
      rd_val = 8'h00;
      if (reg_ana) begin
         if (reg_addr == ADDR_DLY) begin
            rd_val = q.dly;
         end else if (reg_addr == ADDR_APD) begin
            rd_val = q.apd;
         end else if (reg_addr == ADDR_MODE) begin
            rd_val = {2'b00, mode, 3'b000, q.deep_sel};
         end else if (in_ret) begin
            rd_val = q.ret[ret_idx];
         end
      end else begin
         if (reg_addr == ADDR_GRP0) begin
            rd_val = q.grp0;
         end else if (reg_addr == ADDR_GRP1) begin
            rd_val = q.grp1;
         end else if (reg_addr == ADDR_GRP2) begin
            rd_val = q.grp2;
         end
      end
   end

   always_comb begin
      d = q;
      d.slow_prev = pins.clean[IN_SLOW];
      if (reg_rd) begin
         d.rdata = rd_val;
      end
      // software writes
      if (dig_wr) begin
         if (reg_addr == ADDR_GRP0) begin
            d.grp0 = reg_wdata & GRP0_MASK;
         end else if (reg_addr == ADDR_GRP1) begin
            d.grp1 = reg_wdata;
         end else if (reg_addr == ADDR_GRP2) begin
            d.grp2 = reg_wdata;
         end
      end
      if (ana_wr) begin
         if (reg_addr == ADDR_DLY) begin
            d.dly = reg_wdata;
         end else if (reg_addr == ADDR_APD) begin
            d.apd = reg_wdata;
         end else if (reg_addr == ADDR_MODE) begin
            d.deep_sel = reg_wdata[0];
         end else if (in_ret) begin
            d.ret[ret_idx] = reg_wdata;
         end
      end
      // working-mode sequencer
      unique case (q.st)
         st_lockout: begin
            d.ticks = '0;
            if (power_ok) begin
               d.st = q.dly[DLY_OLD] ? st_delay : st_xtal;
            end
         end
         st_xtal: begin
            if (pins.clean[IN_XTAL]) begin
               d.st = st_delay;
            end
         end
         st_delay: begin
            if (slow_rise) begin
               d.ticks = q.ticks + 7'd1;
               if (q.ticks + 7'd1 == target) begin
                  d.st = st_active;
               end
            end
         end
         st_active: begin
            if (pwdn_wr && reg_wdata[PWDN_STALL] && !reg_wdata[PWDN_CHIP]) begin
               if (!reg_wdata[PWDN_SUSP]) begin
                  d.st = st_idle;
               end else if (q.deep_sel) begin
                  d.st = st_deep;
               end else begin
                  d.st = st_suspend;
               end
            end
         end
         st_idle: begin
            if (cpu_irq || wake) begin
               d.st = st_active;
            end
         end
         st_suspend: begin
            d.cnt = '0;
            if (wake) begin
               d.st = st_susp_wake;
            end
         end
         st_susp_wake: begin
            d.cnt = q.cnt + 12'd1;
            if (q.cnt == SUSP_LAST) begin
               d.st = st_active;
            end
         end
         st_deep: begin
            // core unpowered: digital registers lose their contents
            d.grp0 = GRP0_RST;
            d.grp1 = GRP1_RST;
            d.grp2 = GRP2_RST;
            d.deep_sel = 1'b0;
            if (wake) begin
               d.st = st_lockout;
            end
         end
      endcase
      // whole-chip reset from watchdog or software
      if (chip_rst) begin
         d.st = st_lockout;
         d.dly = DLY_RST;
         d.grp0 = GRP0_RST;
         d.grp1 = GRP1_RST;
         d.grp2 = GRP2_RST;
         d.apd = APD_RST;
         d.deep_sel = 1'b0;
         // only the lower retention bytes clear; the upper ones ride through
         for (int i = 0; i < RET_LO_N; i++) begin
            d.ret[i] = 8'h00;
         end
      end
      // supply lockout or reset pin acts as power-on reset
      if (!power_ok) begin
         d = POR_S;
         d.slow_prev = pins.clean[IN_SLOW];
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         q <= POR_S;
      end else begin
         q <= d;
      end
   end

   // outputs
   always_comb begin
      unique case (q.st)
         st_idle: mode = MODE_IDLE;
         st_suspend, st_susp_wake: mode = MODE_SUSPEND;
         st_deep: mode = MODE_DEEP;
         default: mode = MODE_ACTIVE;
      endcase
   end

   assign system_released = released;
   assign cpu_stall = ~released | (q.st == st_idle);
   assign cpu_clk_stop = (mode == MODE_SUSPEND) | (mode == MODE_DEEP);
   assign radio_power_down = cpu_clk_stop;
   assign core_ldo_off = (q.st == st_deep);
   assign module_reset = {q.grp2, q.grp1, q.grp0};
   assign mem_ctrl_reset = q.grp2[GRP2_MEM] & q.grp2[GRP2_MEM_EN];
   assign slow_rc_power_down = q.apd[0] & ~cpu_clk_stop;
   assign slow_crystal_power_down = q.apd[1];
   assign fast_rc_power_down = q.apd[2];
   assign crystal_regulator_power_down = q.apd[3];
   assign analog_power_down_other = q.apd[7:4];
   assign reg_rdata = q.rdata;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   idle_exit_a: assert property (
      (q.st == st_idle && (cpu_irq || wake) && !chip_rst && power_ok)
      |=> mode == MODE_ACTIVE && !cpu_stall)
      else $error("idle did not return to active at once");
   susp_time_a: assert property (
      (q.st == st_susp_wake && !chip_rst && power_ok)
      |=> (q.cnt == $past(q.cnt) + 12'd1 && mode == MODE_SUSPEND)
          || ($past(q.cnt) == SUSP_LAST && mode == MODE_ACTIVE))
      else $error("suspend wake time wrong");
   susp_count_a: assert property (
      (q.st == st_suspend && wake && !chip_rst && power_ok) |=> q.st == st_susp_wake && q.cnt == 12'd0)
      else $error("suspend wake count did not start at zero");
   susp_power_a: assert property (
      (q.st == st_suspend) |-> !core_ldo_off && radio_power_down && cpu_clk_stop)
      else $error("suspend power state wrong");
   ret_keep_a: assert property (
      (chip_rst && power_ok) |=> q.ret[RET_N-1:RET_LO_N] == $past(q.ret[RET_N-1:RET_LO_N]))
      else $error("upper retention lost on chip reset");
   ret_clear_a: assert property (
      (chip_rst && power_ok) |=> q.ret[RET_LO_N-1:0] == '0 && q.st == st_lockout)
      else $error("lower retention not cleared");
   dly_restore_a: assert property (
      chip_rst |=> q.dly == DLY_RST)
      else $error("release delay not restored");
   stall_only_a: assert property (
      (q.st == st_active && pwdn_wr && reg_wdata == 8'h80 && power_ok && !wdt_reset)
      |=> mode == MODE_IDLE && cpu_stall)
      else $error("stall trigger did not stall");
   susp_enter_a: assert property (
      (q.st == st_active && pwdn_wr && reg_wdata == 8'h81 && !q.deep_sel
       && power_ok && !wdt_reset) |=> mode == MODE_SUSPEND)
      else $error("stall trigger did not suspend");
   delay_end_a: assert property (
      (q.st == st_delay && power_ok && !chip_rst)
      |=> system_released == ($past(slow_rise) && ($past(q.ticks) + 7'd1 == $past(target))))
      else $error("release delay count wrong");
   delay_ref_a: assert property (
      (q.dly[6:0] == 7'h7e) |-> target == 7'd32)
      else $error("delay field 7e does not give 32 ticks");
   release_gate_a: assert property (
      !power_ok |=> !system_released [*2])
      else $error("released without supply and pin");
   grp0_write_a: assert property (
      (dig_wr && reg_addr == ADDR_GRP0 && !chip_rst && power_ok && q.st == st_active)
      |=> module_reset[7:0] == ($past(reg_wdata) & GRP0_MASK))
      else $error("group 0 write wrong");
   deep_wake_a: assert property (
      (q.st == st_deep && wake && !chip_rst && power_ok) |=> q.st == st_lockout && !system_released)
      else $error("deep sleep wake did not restart the release path");
   osc_default_a: assert property (
      !power_ok |=> {crystal_regulator_power_down, fast_rc_power_down,
                     slow_crystal_power_down, slow_rc_power_down} == 4'h0)
      else $error("oscillator power-down bits not cleared");
   deep_power_a: assert property (
      (q.st == st_deep) |-> core_ldo_off && radio_power_down && cpu_clk_stop && !system_released)
      else $error("deep sleep power state wrong");
   xtal_wait_a: assert property (
      (q.st == st_xtal && !pins.clean[IN_XTAL] && power_ok && !chip_rst)
      |=> q.st == st_xtal && !system_released)
      else $error("released before crystal ready");
endmodule

// ---- dv/reset_and_power_mode_control_bench.sv ----
// self-checking bench for the reset and power-mode controller
`timescale 1ns/1ps
module reset_and_power_mode_control_bench;
   import pm_pkg::*;
   logic clk = 0, nrst = 0, lock = 1, pin_n = 0, xtal = 1, wpin = 0, wtmr = 0, sclk = 0;
   logic irq = 0, wdt = 0, ana = 0, wr = 0, rd = 0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [1:0] mode;
   logic rel, stall, cstop, rpd, ldo, mrst, p0, p1, p2, p3;
   logic [3:0] pother;
   logic [23:0] mres;
   int n_errors = 0, checks_done = 0, cyc = 0, sdiv = 0, seed = 32'h55057282;
   int am[256], dm[256];

   pm_ctrl dut (
      .clk(clk),
      .nrst(nrst),
      .supply_lockout_released(lock),
      .external_reset_pin_n(pin_n),
      .xtal_ready(xtal),
      .wake_pin(wpin),
      .low_freq_wake_timer(wtmr),
      .slow_clk(sclk),
      .cpu_irq(irq),
      .wdt_reset(wdt),
      .reg_ana(ana),
      .reg_addr(addr),
      .reg_wr(wr),
      .reg_wdata(wdata),
      .reg_rd(rd),
      .reg_rdata(rdata),
      .mode(mode),
      .system_released(rel),
      .cpu_stall(stall),
      .cpu_clk_stop(cstop),
      .radio_power_down(rpd),
      .core_ldo_off(ldo),
      .module_reset(mres),
      .mem_ctrl_reset(mrst),
      .slow_rc_power_down(p0),
      .slow_crystal_power_down(p1),
      .fast_rc_power_down(p2),
      .crystal_regulator_power_down(p3),
      .analog_power_down_other(pother)
   );

   always #50 clk = ~clk;

   // slow clock near 32 kHz: one tick every 312 cycles
   always @(posedge clk) begin
      cyc <= cyc + 1;
      sdiv <= (sdiv == 155) ? 0 : sdiv + 1;
      if (sdiv == 155) sclk <= ~sclk;
      if (cyc == 80000) begin
         n_errors++;
         tally_and_finish;
      end
   end

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask

   task automatic wrt(input logic a, input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk);
      ana <= a;
      addr <= ad;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic put(input logic a, input logic [7:0] ad, input logic [7:0] d);
      wrt(a, ad, d);
      if (a) am[ad] = d;
      else if (ad == ADDR_GRP0) dm[ad] = d & GRP0_MASK;
      else dm[ad] = d;
   endtask

   task automatic rdc(input logic a, input logic [7:0] ad, input int e);
      @(posedge clk);
      ana <= a;
      addr <= ad;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk(rdata, e);
   endtask

   // model of chip, deep sleep and power-on effects on the registers
   task automatic m_deep;
      am[ADDR_MODE] = 0;
      dm[ADDR_GRP0] = GRP0_RST;
      dm[ADDR_GRP1] = GRP1_RST;
      dm[ADDR_GRP2] = GRP2_RST;
   endtask

   task automatic m_chip;
      for (int i = 32'h34; i <= 32'h39; i++) am[i] = 0;
      am[ADDR_APD] = APD_RST;
      am[ADDR_DLY] = DLY_RST;
      m_deep;
   endtask

   task automatic m_por;
      for (int i = 0; i < 256; i++) begin
         am[i] = 0;
         dm[i] = 0;
      end
      m_chip;
   endtask

   function automatic int ticks(input logic [6:0] f);
      logic [6:0] s;
      s = {f[0], f[5:1], f[6]};
      return int'(s >> 1) + 1;
   endfunction

   task automatic wait_rel(input int t);
      int n;
      n = 0;
      while (rel !== 1'b1 && n < t * 312 + 400) begin
         @(negedge clk);
         n++;
      end
      chk(rel === 1'b1 && n >= (t - 1) * 312, 1);
   endtask

   task automatic check_all;
      rdc(1'b1, ADDR_APD, am[ADDR_APD]);
      rdc(1'b1, ADDR_MODE, am[ADDR_MODE]);
      rdc(1'b1, ADDR_DLY, am[ADDR_DLY]);
      for (int i = 32'h34; i <= 32'h3e; i++) rdc(1'b1, i[7:0], am[i]);
      for (int i = 32'h60; i <= 32'h62; i++) rdc(1'b0, i[7:0], dm[i]);
      rdc(1'b0, ADDR_PWDN, 0);
      rdc(1'b1, 8'h10, 0);
      chk(mres, {dm[ADDR_GRP2][7:0], dm[ADDR_GRP1][7:0], dm[ADDR_GRP0][7:0]});
      chk(mrst, dm[ADDR_GRP2][4] & dm[ADDR_GRP2][5]);
      chk({pother, p3, p2, p1, p0}, am[ADDR_APD]);
   endtask

   task automatic fill_ret;
      for (int i = 32'h34; i <= 32'h3e; i++) put(1'b1, i[7:0], 8'($random(seed)));
   endtask

   initial begin
      int n;
      m_por;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      // write while held in reset must be ignored
      wrt(1'b0, ADDR_GRP0, 8'hff);
      settle(500);
      chk({rel, stall}, 2'b01);
      chk(mres, {GRP2_RST, GRP1_RST, GRP0_RST});
      @(posedge clk);
      pin_n <= 1'b1;
      wait_rel(ticks(DLY_RST[6:0]));
      rdc(1'b1, ADDR_DLY, DLY_RST);
      check_all;
      put(1'b0, ADDR_GRP0, 8'hff);
      put(1'b0, ADDR_GRP1, 8'($random(seed)));
      put(1'b0, ADDR_GRP2, 8'h30);
      put(1'b1, ADDR_APD, 8'($random(seed)) | 8'h01);
      fill_ret;
      check_all;
      wrt(1'b0, ADDR_PWDN, 8'h80);
      settle(2);
      chk({mode, rel, stall}, {MODE_IDLE, 2'b11});
      @(posedge clk);
      irq <= 1'b1;
      @(posedge clk);
      irq <= 1'b0;
      settle(2);
      chk({mode, stall}, {MODE_ACTIVE, 1'b0});
      wrt(1'b0, ADDR_PWDN, 8'h81);
      settle(2);
      chk({mode, cstop, rpd, ldo, p0}, {MODE_SUSPEND, 4'b1100});
      @(posedge clk);
      wpin <= 1'b1;
      n = 0;
      while (mode !== MODE_ACTIVE && n < SUSP_WAKE_CYC + 20) begin
         @(negedge clk);
         n++;
      end
      chk(mode === MODE_ACTIVE && n >= SUSP_WAKE_CYC, 1);
      @(posedge clk);
      wpin <= 1'b0;
      put(1'b1, ADDR_MODE, 8'h01);
      put(1'b1, ADDR_DLY, 8'h7e);
      @(posedge clk);
      xtal <= 1'b0;
      wrt(1'b0, ADDR_PWDN, 8'h81);
      m_deep;
      settle(2);
      chk({mode, ldo, cstop}, {MODE_DEEP, 2'b11});
      @(posedge clk);
      wtmr <= 1'b1;
      settle(600);
      chk(rel, 0);
      @(posedge clk);
      wtmr <= 1'b0;
      xtal <= 1'b1;
      wait_rel(ticks(7'h7e));
      check_all;
      // crystal not ready: the default delay mode must not wait for it
      @(posedge clk);
      xtal <= 1'b0;
      // chip reset wins over the stall trigger in the same write
      wrt(1'b0, ADDR_PWDN, 8'ha1);
      m_chip;
      settle(1);
      chk(rel, 0);
      wait_rel(ticks(DLY_RST[6:0]));
      check_all;
      @(posedge clk);
      xtal <= 1'b1;
      fill_ret;
      @(posedge clk);
      wdt <= 1'b1;
      @(posedge clk);
      wdt <= 1'b0;
      m_chip;
      settle(1);
      chk(rel, 0);
      wait_rel(ticks(DLY_RST[6:0]));
      check_all;
      fill_ret;
      // supply drop acts as a power-on reset
      @(posedge clk);
      lock <= 1'b0;
      settle(10);
      chk(rel, 0);
      @(posedge clk);
      lock <= 1'b1;
      m_por;
      wait_rel(ticks(DLY_RST[6:0]));
      check_all;
      tally_and_finish;
   end
endmodule
